// File: rtl/rff_flag_bank.v
`timescale 1ns/1ps
`default_nettype none

// sticky write-one-to-clear flag bank; detection beats any same-cycle clear
module rff_flag_bank #(
  parameter       WIDTH = 4,
  parameter [7:0] RST   = 8'h00
) (
  input  wire             clock,
  input  wire             nrst,
  input  wire [WIDTH-1:0] detect,
  input  wire [WIDTH-1:0] clear,
  output reg  [WIDTH-1:0] flags_q
);

  genvar i;

  // ****************************************
  // one sticky flag per bit
  // ****************************************
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      always @(posedge clock) begin
        if (!nrst) begin
          flags_q[i] <= RST[i];   // per-bit reset value
        end else if (detect[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clear[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/rff_init_edge.v
`timescale 1ns/1ps
`default_nettype none

// one-cycle pulse on entry into the power init state
module rff_init_edge (
  input  wire clock,
  input  wire nrst,
  input  wire in_init,
  output wire enter_pulse
);

  reg in_init_q;

  // ****************************************
  // remember last state for entry detection
  // ****************************************
  always @(posedge clock) begin
    if (!nrst) begin
      in_init_q <= 1'b0;
    end else begin
      in_init_q <= in_init;
    end
  end

  assign enter_pulse = in_init & ~in_init_q;

endmodule

`default_nettype wire

// File: rtl/rff_regs.vh
`ifndef RFF_REGS_VH
`define RFF_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define RFF_LINEAR_FAULT_OFS    8'h2d
`define RFF_BUCK3_FAULT_OFS     8'h2e
`define RFF_SOURCE_SUMMARY_OFS  8'h2b

// ****************************************
// reset values
// ****************************************
`define RFF_LINEAR_FAULT_RST    6'h00
`define RFF_BUCK3_FAULT_RST     4'h0

// ****************************************
// linear regulator register fields
// ****************************************
`define RFF_LIN2_UV_BIT         5
`define RFF_LIN2_OC_BIT         4
`define RFF_LIN2_SCG_BIT        3
`define RFF_LIN1_UV_BIT         2
`define RFF_LIN1_OC_BIT         1
`define RFF_LIN1_SCG_BIT        0
`define RFF_LINEAR_WIDTH        6

// ****************************************
// third buck register fields
// ****************************************
`define RFF_THIRD_STEP_DOWN_UNDERVOLT_FLAG_BIT        3
`define RFF_THIRD_STEP_DOWN_NEGATIVE_CURRENT_FLAG_BIT    2
`define RFF_THIRD_STEP_DOWN_OVERCURRENT_FLAG_BIT        1
`define RFF_THIRD_STEP_DOWN_SHORT_FLAG_BIT       0
`define RFF_BUCK3_WIDTH         4

// ****************************************
// summary register fields
// ****************************************
`define RFF_SUM_LINEAR_BIT      5
`define RFF_SUM_BUCK3_BIT       4

// ****************************************
// undervolt mask bit positions (one per rail)
// ****************************************
`define RFF_MASK_LIN1           0
`define RFF_MASK_LIN2           1
`define RFF_MASK_BUCK3          2
`define RFF_MASK_WIDTH          3

`endif

// File: rtl/rff_regulator_fault_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "rff_regs.vh"

module rff_regulator_fault_flags (
  input  wire       clock,
  input  wire       nrst,
  // register port (address/strobe side of the serial interface)
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  // fault detectors, level high while the fault is present
  input  wire       lin1_uv_det,
  input  wire       lin1_oc_det,
  input  wire       lin1_scg_det,
  input  wire       lin2_uv_det,
  input  wire       lin2_oc_det,
  input  wire       lin2_scg_det,
  input  wire       third_step_down_undervolt_flag_det,
  input  wire       third_step_down_negative_current_flag_det,
  input  wire       third_step_down_overcurrent_flag_det,
  input  wire       third_step_down_short_flag_det,
  // power state and undervolt masks
  input  wire       power_init_state,
  input  wire [2:0] rail_undervolt_mask_bit,
  // flag views
  output reg  [7:0] linear_regulator_fault_flags_q,
  output reg  [7:0] third_buck_fault_flags_q,
  output reg  [7:0] source_summary_q
);

  wire [`RFF_LINEAR_WIDTH-1:0] lin_det;
  wire [`RFF_LINEAR_WIDTH-1:0] lin_clr;
  wire [`RFF_LINEAR_WIDTH-1:0] lin_flags;
  wire [`RFF_BUCK3_WIDTH-1:0]  b3_det;
  wire [`RFF_BUCK3_WIDTH-1:0]  b3_clr;
  wire [`RFF_BUCK3_WIDTH-1:0]  b3_flags;
  wire                         init_enter;
  wire                         wr_lin;
  wire                         wr_b3;
  reg  [7:0]                   rdata_d;

  // address match helper
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ****************************************
  // detector to bit mapping
  // ****************************************
  assign lin_det[`RFF_LIN2_UV_BIT]  = lin2_uv_det;
  assign lin_det[`RFF_LIN2_OC_BIT]  = lin2_oc_det;
  assign lin_det[`RFF_LIN2_SCG_BIT] = lin2_scg_det;
  assign lin_det[`RFF_LIN1_UV_BIT]  = lin1_uv_det;
  assign lin_det[`RFF_LIN1_OC_BIT]  = lin1_oc_det;
  assign lin_det[`RFF_LIN1_SCG_BIT] = lin1_scg_det;
  assign b3_det[`RFF_THIRD_STEP_DOWN_UNDERVOLT_FLAG_BIT]     = third_step_down_undervolt_flag_det;
  assign b3_det[`RFF_THIRD_STEP_DOWN_NEGATIVE_CURRENT_FLAG_BIT] = third_step_down_negative_current_flag_det;
  assign b3_det[`RFF_THIRD_STEP_DOWN_OVERCURRENT_FLAG_BIT]     = third_step_down_overcurrent_flag_det;
  assign b3_det[`RFF_THIRD_STEP_DOWN_SHORT_FLAG_BIT]    = third_step_down_short_flag_det;

  // ****************************************
  // init state entry detection
  // ****************************************
  rff_init_edge u_init_edge (
    .clock       (clock),
    .nrst        (nrst),
    .in_init     (power_init_state),
    .enter_pulse (init_enter)
  );

  // ****************************************
  // clear sources: write-one and init entry
  // ****************************************
  assign wr_lin = reg_wr & hit(reg_addr, `RFF_LINEAR_FAULT_OFS);
  assign wr_b3  = reg_wr & hit(reg_addr, `RFF_BUCK3_FAULT_OFS);

  assign lin_clr[`RFF_LIN2_UV_BIT]  = (wr_lin & reg_wdata[`RFF_LIN2_UV_BIT])
                                      | (init_enter & rail_undervolt_mask_bit[`RFF_MASK_LIN2]);
  assign lin_clr[`RFF_LIN2_OC_BIT]  = wr_lin & reg_wdata[`RFF_LIN2_OC_BIT];
  assign lin_clr[`RFF_LIN2_SCG_BIT] = wr_lin & reg_wdata[`RFF_LIN2_SCG_BIT];
  assign lin_clr[`RFF_LIN1_UV_BIT]  = (wr_lin & reg_wdata[`RFF_LIN1_UV_BIT])
                                      | (init_enter & rail_undervolt_mask_bit[`RFF_MASK_LIN1]);
  assign lin_clr[`RFF_LIN1_OC_BIT]  = wr_lin & reg_wdata[`RFF_LIN1_OC_BIT];
  assign lin_clr[`RFF_LIN1_SCG_BIT] = wr_lin & reg_wdata[`RFF_LIN1_SCG_BIT];

  assign b3_clr[`RFF_THIRD_STEP_DOWN_UNDERVOLT_FLAG_BIT]     = (wr_b3 & reg_wdata[`RFF_THIRD_STEP_DOWN_UNDERVOLT_FLAG_BIT])
                                         | (init_enter & rail_undervolt_mask_bit[`RFF_MASK_BUCK3]);
  assign b3_clr[`RFF_THIRD_STEP_DOWN_NEGATIVE_CURRENT_FLAG_BIT] = wr_b3 & reg_wdata[`RFF_THIRD_STEP_DOWN_NEGATIVE_CURRENT_FLAG_BIT];
  assign b3_clr[`RFF_THIRD_STEP_DOWN_OVERCURRENT_FLAG_BIT]     = wr_b3 & reg_wdata[`RFF_THIRD_STEP_DOWN_OVERCURRENT_FLAG_BIT];
  assign b3_clr[`RFF_THIRD_STEP_DOWN_SHORT_FLAG_BIT]    = wr_b3 & reg_wdata[`RFF_THIRD_STEP_DOWN_SHORT_FLAG_BIT];

  // ****************************************
  // sticky flag banks
  // ****************************************
  rff_flag_bank #(
    .WIDTH (`RFF_LINEAR_WIDTH),
    .RST   ({2'b00, `RFF_LINEAR_FAULT_RST})
  ) u_lin_bank (
    .clock   (clock),
    .nrst    (nrst),
    .detect  (lin_det),
    .clear   (lin_clr),
    .flags_q (lin_flags)
  );

  rff_flag_bank #(
    .WIDTH (`RFF_BUCK3_WIDTH),
    .RST   ({4'h0, `RFF_BUCK3_FAULT_RST})
  ) u_b3_bank (
    .clock   (clock),
    .nrst    (nrst),
    .detect  (b3_det),
    .clear   (b3_clr),
    .flags_q (b3_flags)
  );

  // ****************************************
  // read mux, reserved bits zero, unmapped reads zero
  // ****************************************
  always @* begin
    rdata_d = 8'h00;
    if (hit(reg_addr, `RFF_LINEAR_FAULT_OFS)) begin
      rdata_d = {2'b00, lin_flags};
    end else if (hit(reg_addr, `RFF_BUCK3_FAULT_OFS)) begin
      rdata_d = {4'h0, b3_flags};
    end else if (hit(reg_addr, `RFF_SOURCE_SUMMARY_OFS)) begin
      rdata_d[`RFF_SUM_LINEAR_BIT] = |lin_flags;
      rdata_d[`RFF_SUM_BUCK3_BIT]  = |b3_flags;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge clock) begin
    if (!nrst) begin
      reg_rdata_q                    <= 8'h00;
      linear_regulator_fault_flags_q <= 8'h00;
      third_buck_fault_flags_q       <= 8'h00;
      source_summary_q               <= 8'h00;
    end else begin
      reg_rdata_q                    <= rdata_d;
      linear_regulator_fault_flags_q <= {2'b00, lin_flags};
      third_buck_fault_flags_q       <= {4'h0, b3_flags};
      source_summary_q               <= {2'b00, |lin_flags, |b3_flags, 4'h0};
    end
  end

endmodule

`default_nettype wire

// File: testbench/rff_fault_flags_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rff_fault_flags_sva (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       lin1_uv_det,
  input wire logic       lin1_scg_det,
  input wire logic       third_step_down_undervolt_flag_det,
  input wire logic       third_step_down_negative_current_flag_det,
  input wire logic       third_step_down_overcurrent_flag_det,
  input wire logic       power_init_state,
  input wire logic [2:0] rail_undervolt_mask_bit,
  input wire logic [7:0] linear_regulator_fault_flags_q,
  input wire logic [7:0] third_buck_fault_flags_q,
  input wire logic [7:0] source_summary_q
);
  // short views of the flag outputs and of the linear register write strobe
  wire [7:0] lq = linear_regulator_fault_flags_q;
  wire [7:0] bq = third_buck_fault_flags_q;
  wire       wl = reg_wr && reg_addr == 8'h2d;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_rsv; lq[7:6] == 2'h0 && bq[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_neg; third_step_down_negative_current_flag_det |-> ##[1:2] bq[2]; endproperty
  a_neg: assert property (p_neg) else $error("negative flag missing");
  property p_pos; $rose(bq[1]) |-> $past(third_step_down_overcurrent_flag_det) || $past(third_step_down_overcurrent_flag_det, 2); endproperty
  a_pos: assert property (p_pos) else $error("spurious overcurrent flag");
  property p_w1c; wl && reg_wdata[0] && !lin1_scg_det |-> ##2 !lq[0]; endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_init; $rose(power_init_state) && rail_undervolt_mask_bit[2] && !third_step_down_undervolt_flag_det |-> ##2 !bq[3]; endproperty
  a_init: assert property (p_init) else $error("undervolt not cleared");
  property p_rst; disable iff (1'b0) !nrst |=> lq == 8'h00 && bq == 8'h00 && source_summary_q == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_sum; source_summary_q == {2'h0, |lq, |bq, 4'h0}; endproperty
  a_sum: assert property (p_sum) else $error("summary mismatch");
  property p_win; lin1_uv_det && wl && reg_wdata[2] |-> ##2 lq[2]; endproperty
  a_win: assert property (p_win) else $error("clear beat detection");
endmodule
bind rff_regulator_fault_flags rff_fault_flags_sva sva_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .lin1_uv_det(lin1_uv_det), .lin1_scg_det(lin1_scg_det),
  .third_step_down_undervolt_flag_det(third_step_down_undervolt_flag_det), .third_step_down_negative_current_flag_det(third_step_down_negative_current_flag_det), .third_step_down_overcurrent_flag_det(third_step_down_overcurrent_flag_det),
  .power_init_state(power_init_state), .rail_undervolt_mask_bit(rail_undervolt_mask_bit),
  .linear_regulator_fault_flags_q(linear_regulator_fault_flags_q),
  .third_buck_fault_flags_q(third_buck_fault_flags_q), .source_summary_q(source_summary_q));
`default_nettype wire

// File: testbench/rff_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rff_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata_q,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata
);
  // idle register port
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // one write strobe, ones clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // data lands one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock;
  logic       nrst;
  logic [9:0] det;
  logic       pis;
  logic [2:0] mask;
  logic [7:0] d;
  wire  [7:0] ra, wd, rq, lq, bq, sq;
  wire        wr;
  int         fail_count;
  int         n_tests;
  rff_host_model h_u (.clock(clock), .reg_rdata_q(rq), .reg_addr(ra), .reg_wr(wr), .reg_wdata(wd));
  rff_regulator_fault_flags dut_u (.clock(clock), .nrst(nrst), .reg_addr(ra), .reg_wr(wr), .reg_wdata(wd),
    .reg_rdata_q(rq), .lin1_scg_det(det[0]), .lin1_oc_det(det[1]), .lin1_uv_det(det[2]),
    .lin2_scg_det(det[3]), .lin2_oc_det(det[4]), .lin2_uv_det(det[5]), .third_step_down_short_flag_det(det[6]),
    .third_step_down_overcurrent_flag_det(det[7]), .third_step_down_negative_current_flag_det(det[8]), .third_step_down_undervolt_flag_det(det[9]), .power_init_state(pis),
    .rail_undervolt_mask_bit(mask), .linear_regulator_fault_flags_q(lq), .third_buck_fault_flags_q(bq),
    .source_summary_q(sq));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // each detector alone, then a write with only its own bit zero, then clear
  task automatic s_fields;
    logic [7:0] a, e;
    h_u.rd(8'h2d, d);
    chk(d | lq | bq, 8'h00);
    for (int i = 0; i < 10; i++) begin
      a = (i < 6) ? 8'h2d : 8'h2e;
      e = (i < 6) ? 8'h01 << i : 8'h01 << (i - 6);
      @(posedge clock);
      det <= 10'h001 << i;
      @(posedge clock);
      det <= 10'h000;
      h_u.rd(a, d);
      chk(d, e);
      h_u.rd(8'h2b, d);
      chk(d, (i < 6) ? 8'h20 : 8'h10);
      h_u.wr(a, ~e);
      h_u.rd(a, d);
      chk(d, e);
      h_u.wr(a, 8'hff);
      h_u.rd(a, d);
      chk(d, 8'h00);
    end
  endtask
  // detection against same-edge clear, stray write
  task automatic s_prio;
    @(posedge clock);
    det <= 10'h004;
    h_u.wr(8'h2d, 8'hff);
    det <= 10'h000;
    h_u.wr(8'h2c, 8'hff);
    h_u.rd(8'h2d, d);
    chk(d, 8'h04);
    h_u.rd(8'h2c, d);
    chk(d, 8'h00);
    h_u.wr(8'h2d, 8'h04);
  endtask
  // init entry clears masked undervolt flags only
  task automatic s_init;
    det <= 10'h224;
    @(posedge clock);
    det <= 10'h000;
    mask <= 3'b101;
    pis <= 1'b1;
    h_u.rd(8'h2d, d);
    chk(d, 8'h20);
    h_u.rd(8'h2e, d);
    chk(d, 8'h00);
    @(posedge clock);
    pis <= 1'b0;
    @(posedge clock);
    mask <= 3'b010;
    pis <= 1'b1;
    h_u.rd(8'h2d, d);
    chk(d, 8'h00);
  endtask
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    det = 10'h000;
    pis = 1'b0;
    mask = 3'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    s_fields;
    s_prio;
    s_init;
    conclude;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
